// ===== common/rxs_evt_if.sv
// Purpose: Carries the per-port event strobes from the timing core
// Assumes: Single clock domain
// Notes: All strobes are one-cycle pulses
`timescale 1ns/10ps
interface rxs_evt_if;
  logic frame_tick;
  logic mf_tick;
  logic second_tick;
  logic short_tick;
  logic crc_timeout;
  modport src (output frame_tick, output mf_tick, output second_tick, output short_tick, output crc_timeout);
  modport dst (input frame_tick, input mf_tick, input second_tick, input short_tick, input crc_timeout);
endinterface : rxs_evt_if

// ===== common/rxs_pkg.sv
// Purpose: Constants for the per-port receive status and counter latch block
// Assumes: Byte-wide parallel register port, 250 MHz system clock
// Notes: Offsets are within one port window
package rxs_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] RXS_SYNC_SEARCH_OFS = 12'h062;
  localparam logic [11:0] RXS_ERR_CFG_OFS = 12'h086;
  localparam logic [11:0] RXS_LATCH3_OFS = 12'h092;
  localparam logic [11:0] RXS_LATCH4_OFS = 12'h093;
  localparam logic [11:0] RXS_MASK3_OFS = 12'h0A2;
  localparam logic [11:0] RXS_MASK4_OFS = 12'h0A3;
  localparam logic [11:0] RXS_RT3_OFS = 12'h0B2;
  localparam logic [11:0] RXS_LCV_HI_OFS = 12'h050;
  localparam logic [11:0] RXS_LCV_LO_OFS = 12'h051;
  localparam logic [11:0] RXS_PORT_STRIDE = 12'h200;
  localparam int RXS_NUM_PORTS = 8;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int RXS_CFG_VTYPE = 0;
  localparam int RXS_CFG_ACCUM = 3;
  localparam int RXS_CFG_UPSEL = 4;
  localparam int RXS_CFG_MANUAL = 5;
  localparam int RXS_CFG_MSRC = 6;
  localparam int RXS_CFG_SHARED = 7;
  localparam logic [7:0] RXS_CFG_WMASK = 8'hF9;
  localparam logic [7:0] RXS_MASK3_WMASK = 8'hBB;
  localparam logic [7:0] RXS_MASK4_WMASK = 8'hEF;
  localparam logic [7:0] RXS_RESET_VAL = 8'h00;
  // ****************************************
  // Timing
  // ****************************************
  localparam int RXS_CLK_MHZ = 250;
  localparam int RXS_CHAN_NS = 3906;
  localparam int RXS_CHAN_CYC = (RXS_CHAN_NS * RXS_CLK_MHZ) / 1000;
  localparam int RXS_FRAME_US = 125;
  localparam int RXS_MF_FRAMES = 16;
  localparam int RXS_SEC_FRAMES = 8000;
  localparam int RXS_E1_SHORT_FRAMES = 500;
  localparam int RXS_T1_SHORT_FRAMES = 336;
  localparam int RXS_CRC_SEARCH_FRAMES = 64;
  localparam int RXS_LCV_MAX = 65535;
endpackage : rxs_pkg

// ===== hdl/rxs_port.sv
// Purpose: Receive status, event latches and counter latch control, one port
// Assumes: Receive line inputs already resampled; rx_clk is a pin sampled here
// Notes: Instantiate once per port at base + n * 0x200
//   Address bits above the port window are ignored
//
// Overview of operation
// - Distant multiframe alarm after two set multiframes
// - Clock lost after one channel time idle
// - Link identified while signal detected
// - Rise and fall latches for three conditions
// - Mask bit one lets event interrupt
// - Three search flags in bits 0-2
// - Six-bit search counter, bit 1 hidden
// - Search counter clears on sync or disable
// - Multiframe event every 2 ms
// - Timer event at counter update interval
// - One-second event every second
// - Change-of-state event for enabled channels
// - Elastic store slip, empty, full events
// - Bit 3 selects timed or manual
// - Bit 4 selects second or short interval
// - Manual bit rise loads counts two clocks later
// - Bit 6 selects per-port or global latch
// - Bit 7 uses port 1 second reference
// - Count bipolar or code violations
// - Violation count saturates, ignores sync loss
// - Host write clears latched bit
// - Interrupt low while unmasked event set
`timescale 1ns/10ps
module rxs_port
  import rxs_pkg::*;
#(
  parameter int CHAN_CYC = RXS_CHAN_CYC,
  parameter int CSE_WIDTH = 32
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [11:0] addr,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic rx_clk,
  input wire logic frame_in,
  input wire logic ts16_f0_bit6,
  input wire logic link_id_in,
  input wire logic t1_mode,
  input wire logic crc4_enable,
  input wire logic hdb3_enable,
  input wire logic frame_align_searching,
  input wire logic cas_mf_searching,
  input wire logic crc_mf_searching,
  input wire logic crc_sync_ok,
  input wire logic cas_mf_boundary,
  input wire logic cas_enable,
  input wire logic [CSE_WIDTH-1:0] sig_change,
  input wire logic [CSE_WIDTH-1:0] change_state_enable,
  input wire logic slip_repeat,
  input wire logic slip_delete,
  input wire logic bpv_pulse,
  input wire logic hdb3_code_pulse,
  input wire logic cv_pulse,
  input wire logic global_counter_latch,
  input wire logic port1_second,
  output logic second_out,
  output logic counter_latch,
  output logic [15:0] lcv_count,
  output logic int_n
);
  rxs_evt_if evt ();

  logic [1:0] rck_sync_r, rck_sync_nxt;
  logic rck_prev_r, rck_prev_nxt;
  logic [12:0] idle_cnt_r, idle_cnt_nxt;
  logic rx_clock_lost_r, rx_clock_lost_nxt;
  logic distant_mf_alarm_r, distant_mf_alarm_nxt;
  logic [1:0] dma_run_r, dma_run_nxt;
  logic link_id_seen_r, link_id_seen_nxt;
  logic [2:0] cond_prev_r, cond_prev_nxt;
  logic [7:0] latch3_r, latch3_nxt;
  logic [7:0] latch4_r, latch4_nxt;
  logic [7:0] mask3_r, mask3_nxt;
  logic [7:0] mask4_r, mask4_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic [5:0] crc_search_count_r, crc_search_count_nxt;
  logic manual_prev_r, manual_prev_nxt;
  logic glatch_prev_r, glatch_prev_nxt;
  logic [15:0] lcv_acc_r, lcv_acc_nxt;
  logic [15:0] lcv_hold_r, lcv_hold_nxt;
  logic latch_r, latch_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic wr_prev_r, wr_prev_nxt;
  logic [2:0] cond_now;
  logic [7:0] rt3, sync_status, set3, set4;
  logic wr_stb, lcv_hit, manual_rise, timed_tick, latch_req;
  logic [11:0] local_ofs;

  // Saturating increment shared by the violation path
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'(RXS_LCV_MAX)) ? v : v + 16'h0001;
  endfunction : sat_inc

  // Keeps only the offset inside one port window
  function automatic logic [11:0] port_ofs(input logic [11:0] a);
    return a & (RXS_PORT_STRIDE - 12'h001);
  endfunction : port_ofs

  rxs_timebase u_tb (
    .mclk(mclk),
    .rstn(rstn),
    .frame_in(frame_in),
    .t1_mode(t1_mode),
    .crc_searching(crc_mf_searching),
    .evt(evt.src)
  );

  // ****************************************
  // Address decode
  // ****************************************
  // Port select is decoded outside, so one copy serves every window
  assign local_ofs = port_ofs(addr);

  // ****************************************
  // Condition detectors
  // ****************************************
  // Receive clock is a pin: two flops before any edge logic
  always_comb begin
    rck_sync_nxt = {rck_sync_r[0], rx_clk};
    rck_prev_nxt = rck_sync_r[1];
    // Idle count parks at the limit so it never wraps back to zero
    if (rck_sync_r[1] != rck_prev_r) begin
      idle_cnt_nxt = 13'h0000;
    end else if (idle_cnt_r != 13'(CHAN_CYC)) begin
      idle_cnt_nxt = idle_cnt_r + 13'h0001;
    end else begin
      idle_cnt_nxt = idle_cnt_r;
    end
    rx_clock_lost_nxt = (idle_cnt_r == 13'(CHAN_CYC));
    // No signaling-mode gate on the alarm detector
    // Run count saturates at two; a clear multiframe restarts it
    dma_run_nxt = dma_run_r;
    distant_mf_alarm_nxt = distant_mf_alarm_r;
    if (evt.mf_tick || cas_mf_boundary) begin
      dma_run_nxt = ts16_f0_bit6 ? ((dma_run_r == 2'h2) ? 2'h2 : dma_run_r + 2'h1) : 2'h0;
      distant_mf_alarm_nxt = ts16_f0_bit6 && (dma_run_r != 2'h0);
    end
    link_id_seen_nxt = link_id_in;
  end

  // Registers only; next values come from the block above
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rck_sync_r <= 2'h0;
      rck_prev_r <= 1'b0;
      idle_cnt_r <= 13'h0000;
      rx_clock_lost_r <= 1'b0;
      dma_run_r <= 2'h0;
      distant_mf_alarm_r <= 1'b0;
      link_id_seen_r <= 1'b0;
    end else begin
      rck_sync_r <= rck_sync_nxt;
      rck_prev_r <= rck_prev_nxt;
      idle_cnt_r <= idle_cnt_nxt;
      rx_clock_lost_r <= rx_clock_lost_nxt;
      dma_run_r <= dma_run_nxt;
      distant_mf_alarm_r <= distant_mf_alarm_nxt;
      link_id_seen_r <= link_id_seen_nxt;
    end
  end

  // ****************************************
  // Event sources and counter latch selection
  // ****************************************
  assign cond_now = {rx_clock_lost_r, link_id_seen_r, distant_mf_alarm_r};
  assign rt3 = {4'h0, rx_clock_lost_r, 1'b0, link_id_seen_r, distant_mf_alarm_r};
  // Skipping count bit 1 trades resolution for a longer reach
  assign sync_status = {crc_search_count_r[5:2], crc_search_count_r[0], crc_mf_searching,
                        cas_mf_searching, frame_align_searching};
  assign wr_stb = !cs_n && !wr_n && wr_prev_r;
  assign set3 = {cond_prev_r[2] & ~cond_now[2], 1'b0, cond_prev_r[1] & ~cond_now[1],
                 cond_prev_r[0] & ~cond_now[0], ~cond_prev_r[2] & cond_now[2], 1'b0,
                 ~cond_prev_r[1] & cond_now[1], ~cond_prev_r[0] & cond_now[0]};
  // Multiframe event falls back to the free 2 ms tick without CAS
  assign set4 = {slip_delete, slip_repeat, slip_repeat | slip_delete, 1'b0,
                 |(sig_change & change_state_enable),
                 evt.second_tick,
                 timed_tick,
                 cas_enable ? cas_mf_boundary : evt.mf_tick};
  assign manual_rise = cfg_r[RXS_CFG_MSRC] ? (global_counter_latch && !glatch_prev_r)
                                           : (cfg_r[RXS_CFG_MANUAL] && !manual_prev_r);
  assign timed_tick = cfg_r[RXS_CFG_SHARED] ? port1_second
                    : (cfg_r[RXS_CFG_UPSEL] ? evt.short_tick : evt.second_tick);
  assign latch_req = cfg_r[RXS_CFG_ACCUM] ? manual_rise : timed_tick;
  // Code violations are counted only when selected; bipolar violations otherwise
  assign lcv_hit = cfg_r[RXS_CFG_VTYPE] ? cv_pulse : (bpv_pulse && !(hdb3_enable && hdb3_code_pulse));

  // ****************************************
  // Register file and latched status
  // ****************************************
  always_comb begin
    wr_prev_nxt = cs_n || wr_n;
    cond_prev_nxt = cond_now;
    manual_prev_nxt = cfg_r[RXS_CFG_MANUAL];
    glatch_prev_nxt = global_counter_latch;
    latch3_nxt = latch3_r;
    latch4_nxt = latch4_r;
    mask3_nxt = mask3_r;
    mask4_nxt = mask4_r;
    cfg_nxt = cfg_r;
    // Unmapped write offsets change nothing
    if (wr_stb) begin
      unique case (local_ofs)
        RXS_LATCH3_OFS: latch3_nxt = latch3_r & ~wdata;
        RXS_LATCH4_OFS: latch4_nxt = latch4_r & ~wdata;
        RXS_MASK3_OFS: mask3_nxt = wdata & RXS_MASK3_WMASK;
        RXS_MASK4_OFS: mask4_nxt = wdata & RXS_MASK4_WMASK;
        RXS_ERR_CFG_OFS: cfg_nxt = wdata & RXS_CFG_WMASK;
        default: cfg_nxt = cfg_r;
      endcase
    end
    // New events win over a clear in the same cycle
    latch3_nxt = latch3_nxt | set3;
    latch4_nxt = latch4_nxt | set4;
    crc_search_count_nxt = crc_search_count_r;
    if (crc_sync_ok || !crc4_enable) begin
      crc_search_count_nxt = 6'h00;
    end else if (evt.crc_timeout) begin
      crc_search_count_nxt = crc_search_count_r + 6'h01;
    end
    // Counts in all sync states; snapshot resets the accumulator
    latch_nxt = latch_req;
    lcv_hold_nxt = latch_r ? lcv_acc_r : lcv_hold_r;
    if (latch_r) begin
      lcv_acc_nxt = {15'h0000, lcv_hit};
    end else begin
      lcv_acc_nxt = lcv_hit ? sat_inc(lcv_acc_r) : lcv_acc_r;
    end
    // Unselected reads return zero; data lands one cycle later
    rdata_nxt = RXS_RESET_VAL;
    if (!cs_n && !rd_n) begin
      unique case (local_ofs)
        RXS_SYNC_SEARCH_OFS: rdata_nxt = sync_status;
        RXS_ERR_CFG_OFS: rdata_nxt = cfg_r;
        RXS_LATCH3_OFS: rdata_nxt = latch3_r;
        RXS_LATCH4_OFS: rdata_nxt = latch4_r;
        RXS_MASK3_OFS: rdata_nxt = mask3_r;
        RXS_MASK4_OFS: rdata_nxt = mask4_r;
        RXS_RT3_OFS: rdata_nxt = rt3;
        RXS_LCV_HI_OFS: rdata_nxt = lcv_hold_r[15:8];
        RXS_LCV_LO_OFS: rdata_nxt = lcv_hold_r[7:0];
        default: rdata_nxt = RXS_RESET_VAL;
      endcase
    end
  end

  // Write edge tracker resets high so the first strobe after reset is taken
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_prev_r <= 1'b1;
      cond_prev_r <= 3'h0;
      manual_prev_r <= 1'b0;
      glatch_prev_r <= 1'b0;
      latch3_r <= RXS_RESET_VAL;
      latch4_r <= RXS_RESET_VAL;
      mask3_r <= RXS_RESET_VAL;
      mask4_r <= RXS_RESET_VAL;
      cfg_r <= RXS_RESET_VAL;
      crc_search_count_r <= 6'h00;
      latch_r <= 1'b0;
      lcv_hold_r <= 16'h0000;
      lcv_acc_r <= 16'h0000;
      rdata_r <= RXS_RESET_VAL;
    end else begin
      wr_prev_r <= wr_prev_nxt;
      cond_prev_r <= cond_prev_nxt;
      manual_prev_r <= manual_prev_nxt;
      glatch_prev_r <= glatch_prev_nxt;
      latch3_r <= latch3_nxt;
      latch4_r <= latch4_nxt;
      mask3_r <= mask3_nxt;
      mask4_r <= mask4_nxt;
      cfg_r <= cfg_nxt;
      crc_search_count_r <= crc_search_count_nxt;
      latch_r <= latch_nxt;
      lcv_hold_r <= lcv_hold_nxt;
      lcv_acc_r <= lcv_acc_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata = rdata_r;
  assign second_out = evt.second_tick;
  assign counter_latch = latch_r;
  assign lcv_count = lcv_hold_r;
  // Interrupt built from flops only, so bus activity cannot glitch it
  assign int_n = !(|(latch3_r & mask3_r) || |(latch4_r & mask4_r));
endmodule : rxs_port

// ===== hdl/rxs_timebase.sv
// Purpose: Frame-derived timers for one port
// Assumes: Frame strobe comes from the receive clock via the main module
// Notes: CRC search timer only runs while searching
`timescale 1ns/10ps
module rxs_timebase
  import rxs_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic frame_in,
  input wire logic t1_mode,
  input wire logic crc_searching,
  rxs_evt_if.src evt
);
  logic [3:0] mf_cnt_r, mf_cnt_nxt;
  logic [12:0] sec_cnt_r, sec_cnt_nxt;
  logic [8:0] sh_cnt_r, sh_cnt_nxt;
  logic [5:0] crc_cnt_r, crc_cnt_nxt;
  logic [8:0] sh_last;

  // ****************************************
  // Counters
  // ****************************************
  // Short interval length depends on line standard
  always_comb begin
    sh_last = t1_mode ? 9'(RXS_T1_SHORT_FRAMES - 1) : 9'(RXS_E1_SHORT_FRAMES - 1);
    mf_cnt_nxt = mf_cnt_r;
    sec_cnt_nxt = sec_cnt_r;
    sh_cnt_nxt = sh_cnt_r;
    crc_cnt_nxt = crc_searching ? crc_cnt_r : 6'h00;
    if (frame_in) begin
      mf_cnt_nxt = mf_cnt_r + 4'h1;
      sec_cnt_nxt = (sec_cnt_r == 13'(RXS_SEC_FRAMES - 1)) ? 13'h0000 : sec_cnt_r + 13'h0001;
      sh_cnt_nxt = (sh_cnt_r >= sh_last) ? 9'h000 : sh_cnt_r + 9'h001;
      if (crc_searching) begin
        crc_cnt_nxt = crc_cnt_r + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mf_cnt_r <= 4'h0;
      sec_cnt_r <= 13'h0000;
      sh_cnt_r <= 9'h000;
      crc_cnt_r <= 6'h00;
    end else begin
      mf_cnt_r <= mf_cnt_nxt;
      sec_cnt_r <= sec_cnt_nxt;
      sh_cnt_r <= sh_cnt_nxt;
      crc_cnt_r <= crc_cnt_nxt;
    end
  end

  // Arbitrary 2 ms boundary when no CAS alignment is present
  assign evt.frame_tick = frame_in;
  assign evt.mf_tick = frame_in && (mf_cnt_r == 4'(RXS_MF_FRAMES - 1));
  assign evt.second_tick = frame_in && (sec_cnt_r == 13'(RXS_SEC_FRAMES - 1));
  assign evt.short_tick = frame_in && (sh_cnt_r >= sh_last);
  assign evt.crc_timeout = frame_in && crc_searching && (crc_cnt_r == 6'(RXS_CRC_SEARCH_FRAMES - 1));
endmodule : rxs_timebase

// ===== sim/rxs_host_model.sv
// Purpose: Host processor on the parallel register port
// Assumes: Called at the falling clock edge
// Notes: Bus is scrambled when released so stale data never matches
`timescale 1ns/10ps
module rxs_host_model
  import rxs_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] rdata,
  output logic [11:0] addr,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic [7:0] wdata
);
  initial begin
    addr = 12'h000;
    wdata = 8'h00;
    {cs_n, wr_n, rd_n} = 3'h7;
  end
  // Strobe spans one rising edge, then idles a cycle before the next
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    {cs_n, wr_n} = 2'h0;
    @(negedge mclk);
    {cs_n, wr_n} = 2'h3;
    addr = ~a;
    wdata = ~d;
    @(negedge mclk);
  endtask : wr
  // Read held two edges; registered data is taken after the second
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    addr = a;
    {cs_n, rd_n} = 2'h0;
    repeat (2) @(negedge mclk);
    d = rdata;
    {cs_n, rd_n} = 2'h3;
    addr = ~a;
    @(negedge mclk);
  endtask : rd
endmodule : rxs_host_model

// ===== sim/rxs_port_chk.sv
// Purpose: Pin-level assertions for one receive status port
// Assumes: Mask and config values are mirrored from host writes
// Notes: Bound into every rxs_port instance
`timescale 1ns/10ps
module rxs_port_chk
  import rxs_pkg::*;
#(
  parameter int CHAN_CYC = RXS_CHAN_CYC
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [11:0] addr,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rx_clk,
  input wire logic link_id_in,
  input wire logic crc_mf_searching,
  input wire logic global_counter_latch,
  input wire logic port1_second,
  input wire logic counter_latch,
  input wire logic int_n
);
  logic rd, wsel, wtake, wq_r, ck_r;
  logic [7:0] m3_r, m3_nxt, m4_r, m4_nxt, cfg_r, cfg_nxt;
  logic [15:0] idle_r, idle_nxt;
  // ****
  // Write mirror
  // ****
  // Mirrors apply the write masks, so refused bits never look set
  always_comb begin
    rd = !cs_n && !rd_n;
    wsel = !cs_n && !wr_n;
    wtake = wsel && !wq_r;
    m3_nxt = (wtake && addr == RXS_MASK3_OFS) ? (wdata & RXS_MASK3_WMASK) : m3_r;
    m4_nxt = (wtake && addr == RXS_MASK4_OFS) ? (wdata & RXS_MASK4_WMASK) : m4_r;
    cfg_nxt = (wtake && addr == RXS_ERR_CFG_OFS) ? (wdata & RXS_CFG_WMASK) : cfg_r;
    idle_nxt = (rx_clk != ck_r) ? 16'h0000 : idle_r + {15'h0000, idle_r != 16'hFFFF};
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wq_r <= 1'b0;
      ck_r <= 1'b0;
      m3_r <= 8'h00;
      m4_r <= 8'h00;
      cfg_r <= 8'h00;
      idle_r <= 16'h0000;
    end else begin
      wq_r <= wsel;
      ck_r <= rx_clk;
      m3_r <= m3_nxt;
      m4_r <= m4_nxt;
      cfg_r <= cfg_nxt;
      idle_r <= idle_nxt;
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  mask3_rdback_a: assert property (rd && addr == RXS_MASK3_OFS |=> rdata == m3_r)
    else $error("mask 3 readback wrong");
  mask4_rdback_a: assert property (rd && addr == RXS_MASK4_OFS |=> rdata == m4_r)
    else $error("mask 4 readback wrong");
  latch3_unused_a: assert property (rd && addr == RXS_LATCH3_OFS |=> !rdata[2] && !rdata[6])
    else $error("unused latch bit set");
  masked_quiet_a: assert property (m3_r == 8'h00 && m4_r == 8'h00 |-> int_n)
    else $error("interrupt with all masked");
  clk_lost_a: assert property (rd && addr == RXS_RT3_OFS && idle_r > CHAN_CYC + 4 |=> rdata[3])
    else $error("idle line clock not flagged");
  link_rd_a: assert property ($stable(link_id_in)[*4] ##0 (rd && addr == RXS_RT3_OFS) |=>
    rdata[1] == $past(link_id_in))
    else $error("link flag wrong");
  crc_flag_a: assert property ($stable(crc_mf_searching)[*3] ##0 (rd && addr == RXS_SYNC_SEARCH_OFS) |=>
    rdata[2] == $past(crc_mf_searching))
    else $error("search flag wrong");
  manual_latch_a: assert property (wtake && addr == RXS_ERR_CFG_OFS && wdata[3] && !wdata[6] && wdata[5]
    && !cfg_r[5] |-> ##[1:3] counter_latch)
    else $error("manual latch missing");
  global_latch_a: assert property (cfg_r[3] && cfg_r[6] && $rose(global_counter_latch)
    |-> ##[1:4] counter_latch)
    else $error("global latch missing");
  shared_sec_a: assert property (!cfg_r[3] && cfg_r[7] && port1_second |-> ##[1:3] counter_latch)
    else $error("shared second latch missing");
  cover property (counter_latch);
  cover property (!int_n);
  cover property (rd && addr == RXS_RT3_OFS && idle_r > CHAN_CYC);
endmodule : rxs_port_chk
bind rxs_port rxs_port_chk #(.CHAN_CYC(CHAN_CYC)) rxs_port_chk_i (.mclk, .rstn, .addr, .cs_n, .wr_n, .rd_n,
  .wdata, .rdata, .rx_clk, .link_id_in, .crc_mf_searching, .global_counter_latch, .port1_second,
  .counter_latch, .int_n);

// ===== sim/rxs_port_tb.sv
// Purpose: Self-checking bench for one receive status port
// Assumes: Channel time shortened to CC cycles
// Notes: Inputs change at the falling edge only, except the free-running rx_clk
`timescale 1ns/10ps
module rxs_port_tb;
  import rxs_pkg::*;
  localparam int CC = 10;
  logic mclk = 1'b0, rstn = 1'b0, rx_clk = 1'b0, rx_run = 1'b1;
  logic [11:0] addr;
  logic cs_n, wr_n, rd_n, second_out, counter_latch, int_n;
  logic [7:0] wdata, rdata;
  logic [15:0] lcv_count;
  logic frame_in = 1'b0, ts16_f0_bit6 = 1'b0, link_id_in = 1'b0, t1_mode = 1'b0, crc4_enable = 1'b1;
  logic hdb3_enable = 1'b0, frame_align_searching = 1'b0, cas_mf_searching = 1'b0, crc_mf_searching = 1'b0;
  logic crc_sync_ok = 1'b0, cas_mf_boundary = 1'b0, cas_enable = 1'b0, slip_repeat = 1'b0, slip_delete = 1'b0;
  logic bpv_pulse = 1'b0, hdb3_code_pulse = 1'b0, cv_pulse = 1'b0, global_counter_latch = 1'b0, port1_second = 1'b0;
  logic [31:0] sig_change = 32'h0, change_state_enable = 32'h20;
  logic [11:0] ofs [8] = '{RXS_SYNC_SEARCH_OFS, RXS_ERR_CFG_OFS, RXS_LATCH3_OFS, RXS_LATCH4_OFS,
    RXS_MASK3_OFS, RXS_MASK4_OFS, RXS_RT3_OFS, 12'h07F};
  int errors = 0;
  int n_tests = 0;
  rxs_port #(.CHAN_CYC(CC)) rxs_port_i (.mclk, .rstn, .addr, .cs_n, .wr_n, .rd_n, .wdata, .rdata, .rx_clk,
    .frame_in, .ts16_f0_bit6, .link_id_in, .t1_mode, .crc4_enable, .hdb3_enable, .frame_align_searching,
    .cas_mf_searching, .crc_mf_searching, .crc_sync_ok, .cas_mf_boundary, .cas_enable, .sig_change,
    .change_state_enable, .slip_repeat, .slip_delete, .bpv_pulse, .hdb3_code_pulse, .cv_pulse,
    .global_counter_latch, .port1_second, .second_out, .counter_latch, .lcv_count, .int_n);
  rxs_host_model rxs_host_model_i (.mclk, .rdata, .addr, .cs_n, .wr_n, .rd_n, .wdata);
  // ****
  // Clocks and watchdog
  // ****
  initial begin
    forever #2 mclk = ~mclk;
  end
  // Line clock unrelated in phase; freezes to fake a lost clock
  initial begin
    forever #7.3 rx_clk = rx_run ? ~rx_clk : rx_clk;
  end
  initial begin
    #400000;
    errors++;
    final_report();
  end
  // ****
  // Helpers
  // ****
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] v;
    rxs_host_model_i.rd(a, v);
    chk({8'h00, v}, {8'h00, e});
  endtask : rchk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    rxs_host_model_i.wr(a, d);
  endtask : wr
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask : pulse
  task automatic frames(input int n);
    repeat (n) pulse(frame_in);
  endtask : frames
  task automatic final_report;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  // ****
  // Tests
  // ****
  initial begin
    tick(20);
    rstn = 1'b1;
    tick(1);
    foreach (ofs[i]) rchk(ofs[i], 8'h00);
    chk({15'h0, int_n}, 16'h1);
    wr(RXS_MASK3_OFS, RXS_MASK3_WMASK);
    rchk(RXS_MASK3_OFS, 8'hBB);
    wr(RXS_MASK4_OFS, 8'hE0);
    pulse(slip_repeat);
    rchk(RXS_LATCH4_OFS, 8'h60);
    chk({15'h0, int_n}, 16'h0);
    wr(RXS_LATCH4_OFS, 8'h60);
    rchk(RXS_LATCH4_OFS, 8'h00);
    chk({15'h0, int_n}, 16'h1);
    wr(RXS_MASK4_OFS, 8'h00);
    pulse(slip_delete);
    rchk(RXS_LATCH4_OFS, 8'hA0);
    chk({15'h0, int_n}, 16'h1);
    wr(RXS_LATCH4_OFS, 8'hFF);
    // Disabled channel first, then an enabled one
    sig_change = 32'h10;
    tick(1);
    sig_change = 32'h0;
    rchk(RXS_LATCH4_OFS, 8'h00);
    sig_change = 32'h20;
    tick(1);
    sig_change = 32'h0;
    rchk(RXS_LATCH4_OFS, 8'h08);
    wr(RXS_LATCH4_OFS, 8'hFF);
    link_id_in = 1'b1;
    tick(4);
    rchk(RXS_RT3_OFS, 8'h02);
    link_id_in = 1'b0;
    tick(4);
    rchk(RXS_LATCH3_OFS, 8'h22);
    chk({15'h0, int_n}, 16'h0);
    wr(RXS_LATCH3_OFS, 8'hFF);
    rx_run = 1'b0;
    tick(3 * CC);
    rchk(RXS_RT3_OFS, 8'h08);
    rx_run = 1'b1;
    tick(8);
    rchk(RXS_RT3_OFS, 8'h00);
    rchk(RXS_LATCH3_OFS, 8'h88);
    wr(RXS_LATCH3_OFS, 8'hFF);
    // Timed short interval; search count 8 shows as bit 5
    wr(RXS_ERR_CFG_OFS, 8'h10);
    {frame_align_searching, cas_mf_searching, crc_mf_searching, ts16_f0_bit6} = 4'hF;
    frames(520);
    rchk(RXS_SYNC_SEARCH_OFS, 8'h27);
    rchk(RXS_LATCH3_OFS, 8'h01);
    rchk(RXS_LATCH4_OFS, 8'h03);
    crc4_enable = 1'b0;
    rchk(RXS_SYNC_SEARCH_OFS, 8'h07);
    crc_mf_searching = 1'b0;
    wr(RXS_LATCH4_OFS, 8'hFF);
    frames(7479);
    // Last frame of the second: the strobe stands while frame_in does
    frame_in = 1'b1;
    #1 chk({15'h0, second_out}, 16'h1);
    pulse(frame_in);
    rchk(RXS_LATCH4_OFS, 8'h07);
    cas_enable = 1'b1;
    wr(RXS_LATCH4_OFS, 8'hFF);
    pulse(cas_mf_boundary);
    rchk(RXS_LATCH4_OFS, 8'h01);
    // Manual latch; an HDB3 substitution must not count
    wr(RXS_ERR_CFG_OFS, 8'h08);
    hdb3_enable = 1'b1;
    {bpv_pulse, hdb3_code_pulse} = 2'h3;
    tick(1);
    {bpv_pulse, hdb3_code_pulse} = 2'h0;
    hdb3_enable = 1'b0;
    repeat (5) pulse(bpv_pulse);
    wr(RXS_ERR_CFG_OFS, 8'h28);
    tick(62500);
    rchk(RXS_LCV_HI_OFS, 8'h00);
    rchk(RXS_LCV_LO_OFS, 8'h05);
    wr(RXS_ERR_CFG_OFS, 8'h09);
    repeat (3) pulse(bpv_pulse);
    repeat (2) pulse(cv_pulse);
    wr(RXS_ERR_CFG_OFS, 8'h29);
    tick(4);
    chk(lcv_count, 16'h0002);
    wr(RXS_ERR_CFG_OFS, 8'h48);
    pulse(bpv_pulse);
    global_counter_latch = 1'b1;
    tick(6);
    chk(lcv_count, 16'h0001);
    global_counter_latch = 1'b0;
    wr(RXS_ERR_CFG_OFS, 8'h80);
    repeat (3) pulse(bpv_pulse);
    pulse(port1_second);
    tick(4);
    chk(lcv_count, 16'h0003);
    final_report();
  end
endmodule : rxs_port_tb
